/* File: logic/cse_evt_map.svh */
// Purpose: offsets, field positions, event codes and reset values of the sleep event block
// Assumes: included by bare name wherever a constant is needed
// Notes:   definitions only
`ifndef CSE_EVT_MAP_SVH
`define CSE_EVT_MAP_SVH

// ==========================================================
// register offsets (byte addresses, 32-bit words)
`define CSE_OFS_CTRL0     8'h00
`define CSE_OFS_CTRL1     8'h04
`define CSE_OFS_CTRL2     8'h08
`define CSE_OFS_CTRL3     8'h0c
`define CSE_OFS_COUNT0    8'h10
`define CSE_OFS_COUNT1    8'h14
`define CSE_OFS_COUNT2    8'h18
`define CSE_OFS_COUNT3    8'h1c
`define CSE_OFS_FILTER    8'h20
`define CSE_OFS_STATUS    8'h24

// ==========================================================
// control register fields
`define CSE_CTRL_CODE_HI  7
`define CSE_CTRL_CODE_LO  0
`define CSE_CTRL_EXT_BIT  21
`define CSE_CTRL_EN_BIT   22
`define CSE_FILT_HI       7
`define CSE_FILT_LO       0

// ==========================================================
// word select field of the byte address, four banked words
`define CSE_SEL_HI        3
`define CSE_SEL_LO        2

// ==========================================================
// reset values
`define CSE_RST_CODE      8'h00
`define CSE_RST_FILTER    8'h00
`define CSE_RST_COUNT     32'h0000_0000
`define CSE_RD_ZERO       32'h0000_0000

// ==========================================================
// event codes
`define CSE_CODE_TRANS_C4 8'h74
`define CSE_CODE_TRANS_C9 8'h79
`define CSE_CODE_REJ_C0   8'h17
`define CSE_CODE_REJ_C9   8'h20
`define CSE_CODE_REJ_C10  8'h21
`define CSE_CODE_REJ_C14  8'h25
`define CSE_CODE_DEM_C0   8'h1e
`define CSE_FILT_DEM_BIT  0

// ==========================================================
// clock figures: counting clock and the rate it stands in for
`define CSE_CLK_MHZ       250
`define CSE_PCLK_MHZ      800

`endif

/* File: logic/cse_pkg.sv */
// Purpose: shared types of the sleep event block
// Assumes: constants live in cse_evt_map.svh
// Notes:   types only
package cse_pkg;
  typedef logic [31:0] cse_word_type;

  typedef struct packed {
    logic       en;
    logic       ext;
    logic [7:0] code;
  } cse_ctrl_type;

  // deep-sleep request tracker, one per core
  typedef enum logic [1:0] {
    DLY_IDLE = 2'b01,
    DLY_WAIT = 2'b10
  } cse_dly_type;
endpackage : cse_pkg

/* File: logic/cse_cnt_if.sv */
// Purpose: carries control, events and count between the top and one counter slice
// Assumes: one instance per general counter
// Notes:   no clocking block
`timescale 1ns/1ns
interface cse_cnt_if;
  cse_pkg::cse_ctrl_type ctrl;
  logic                  load;
  cse_pkg::cse_word_type loadVal;
  logic [5:0]            transEvt;
  logic [14:0]           rejEvt;
  logic                  demEvt;
  cse_pkg::cse_word_type count;

  modport top   (output ctrl, load, loadVal, transEvt, rejEvt, demEvt, input count);
  modport slice (input ctrl, load, loadVal, transEvt, rejEvt, demEvt, output count);
endinterface : cse_cnt_if

/* File: logic/cse_counter.sv */
// Purpose: one general counter: selects an event by code and accumulates it
// Assumes: event inputs are one-bit per cycle, synchronous to ref_clk
// Notes:   at most one increment per cycle
`timescale 1ns/1ns
`include "cse_evt_map.svh"
module cse_counter (
  input  wire logic  ref_clk,  // counting clock
  input  wire logic  nrst,     // async reset, active low
  cse_cnt_if.slice   bus       // control in, count out
);
  logic                  selEvt;
  cse_pkg::cse_word_type count;
  cse_pkg::cse_word_type next_count;

  // ==========================================================
  // event select
  // decode of code plus extra bit; codes overlap so ext must split them
  always_comb
  begin
    selEvt = 1'b0;
    if (bus.ctrl.ext)
    begin
      if (bus.ctrl.code >= `CSE_CODE_REJ_C0 && bus.ctrl.code <= `CSE_CODE_REJ_C9)
        selEvt = bus.rejEvt[4'(bus.ctrl.code - `CSE_CODE_REJ_C0)];
      else if (bus.ctrl.code >= `CSE_CODE_REJ_C10 && bus.ctrl.code <= `CSE_CODE_REJ_C14)
        selEvt = bus.rejEvt[4'(bus.ctrl.code - `CSE_CODE_REJ_C0)];
    end
    else
    begin
      if (bus.ctrl.code >= `CSE_CODE_TRANS_C4 && bus.ctrl.code <= `CSE_CODE_TRANS_C9)
        selEvt = bus.transEvt[3'(bus.ctrl.code - `CSE_CODE_TRANS_C4)];
      else if (bus.ctrl.code == `CSE_CODE_DEM_C0)
        selEvt = bus.demEvt;
    end
  end

  // ==========================================================
  // accumulate
  // a software load wins over a same-cycle increment
  always_comb
  begin
    next_count = count;
    if (bus.load)
      next_count = bus.loadVal;
    else if (bus.ctrl.en && selEvt)
      next_count = count + 32'h0000_0001;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      count <= `CSE_RST_COUNT;
    else
      count <= next_count;
  end

  assign bus.count = count;
endmodule : cse_counter

/* File: logic/cse_sleep_events.sv */
// Purpose: per-core sleep-state event sources feeding four general counters
// Assumes: sequencer inputs are synchronous to ref_clk; plain register port
// Notes:   counting clock here is ref_clk; see map for the nominal rate
`timescale 1ns/1ns
`include "cse_evt_map.svh"
module cse_sleep_events (
  input  wire logic        ref_clk,    // counting clock
  input  wire logic        nrst,       // async reset, active low
  input  wire logic [7:0]  regAddr,    // register byte address
  input  wire logic [31:0] regWdata,   // write data
  input  wire logic        regWr,      // write strobe
  input  wire logic        regRd,      // read strobe
  output logic      [31:0] regRdata,   // read data, cycle after regRd
  input  wire logic [5:0]  seqBusy,    // cores 4..9 sequencer in transition
  input  wire logic [5:0]  fvChange,   // cores 4..9 frequency/voltage step
  input  wire logic [14:0] deepReq,    // cores 0..14 deep sleep request pulse
  input  wire logic [14:0] wakeEvt,    // cores 0..14 wake event pulse
  input  wire logic [14:0] timerDone,  // cores 0..14 delay timer expired
  input  wire logic        demote0     // core 0 sleep demotion pulse
);
  // ==========================================================
  // declarations
  cse_pkg::cse_ctrl_type ctrl      [4];
  cse_pkg::cse_ctrl_type next_ctrl [4];
  logic [7:0]            filter;
  logic [7:0]            next_filter;
  cse_pkg::cse_word_type rdData;
  cse_pkg::cse_word_type next_rdData;
  cse_pkg::cse_dly_type  dly       [15];
  cse_pkg::cse_dly_type  next_dly  [15];
  logic [14:0]           rejPulse;
  logic [14:0]           next_rejPulse;
  logic [5:0]            transEvt;
  logic                  demEvt;
  logic [3:0]            loadSel;
  logic [1:0]            regSel;
  cse_pkg::cse_word_type countVal  [4];

  cse_cnt_if cnt [4] ();

  // ==========================================================
  // register word select
  // one decode of the word index serves write, load and read, so the three
  // paths can never disagree on which counter or control word is meant
  assign regSel = regAddr[`CSE_SEL_HI:`CSE_SEL_LO];

  // ==========================================================
  // per-core transition cycle events
  // a core busy with a sequence and a step at once counts nothing that cycle
  // mask out frequency and voltage steps
  // bit i looks at core i+4 only
  assign transEvt = seqBusy & ~fvChange;

  assign demEvt = demote0 & filter[`CSE_FILT_DEM_BIT];

  // ==========================================================
  // deep-sleep rejection trackers
  // a new request while waiting just restarts the wait; a wake and an expiry
  // in the same cycle is an entry, not a rejection, since the timer made it
  // limitation: a request beside a wake or expiry while waiting is dropped;
  // the sequencer is assumed never to raise both for one core at once
  always_comb
  begin
    next_rejPulse = '0;
    for (int i = 0; i < 15; i++)
    begin
      next_dly[i] = dly[i];
      unique case (dly[i])
        cse_pkg::DLY_IDLE:
        begin
          if (deepReq[i])
            next_dly[i] = cse_pkg::DLY_WAIT;
        end
        cse_pkg::DLY_WAIT:
        begin
          if (timerDone[i])
            next_dly[i] = cse_pkg::DLY_IDLE;
          else if (wakeEvt[i])
          begin
            next_dly[i]      = cse_pkg::DLY_IDLE;
            next_rejPulse[i] = 1'b1;
          end
        end
        // an illegal code, say from an upset, falls back to idle uncounted
        default:
          next_dly[i] = cse_pkg::DLY_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rejPulse <= '0;
      for (int i = 0; i < 15; i++)
        dly[i] <= cse_pkg::DLY_IDLE;
    end
    else
    begin
      rejPulse <= next_rejPulse;
      for (int i = 0; i < 15; i++)
        dly[i] <= next_dly[i];
    end
  end

  // ==========================================================
  // register writes
  // the status word is read only, so a write to it falls into the default
  // and is dropped like any unmapped write
  always_comb
  begin
    next_filter = filter;
    loadSel     = '0;
    for (int k = 0; k < 4; k++)
      next_ctrl[k] = ctrl[k];
    if (regWr)
    begin
      unique case (regAddr)
        `CSE_OFS_CTRL0, `CSE_OFS_CTRL1, `CSE_OFS_CTRL2, `CSE_OFS_CTRL3:
        begin
          next_ctrl[regSel].code = regWdata[`CSE_CTRL_CODE_HI:`CSE_CTRL_CODE_LO];
          next_ctrl[regSel].ext  = regWdata[`CSE_CTRL_EXT_BIT];
          next_ctrl[regSel].en   = regWdata[`CSE_CTRL_EN_BIT];
        end
        // a load beats the increment of the same edge inside the slice
        `CSE_OFS_COUNT0, `CSE_OFS_COUNT1, `CSE_OFS_COUNT2, `CSE_OFS_COUNT3:
          loadSel[regSel] = 1'b1;
        `CSE_OFS_FILTER:
          next_filter = regWdata[`CSE_FILT_HI:`CSE_FILT_LO];
        default:
          next_filter = filter;
      endcase
    end
  end

  // ==========================================================
  // register reads, registered one cycle; unmapped reads zero
  // a count read returns the value before this edge's increment, so software
  // always sees a figure one cycle old; that is the price of registered data
  always_comb
  begin
    next_rdData = `CSE_RD_ZERO;
    if (regRd)
    begin
      unique case (regAddr)
        `CSE_OFS_CTRL0, `CSE_OFS_CTRL1, `CSE_OFS_CTRL2, `CSE_OFS_CTRL3:
        begin
          next_rdData[`CSE_CTRL_CODE_HI:`CSE_CTRL_CODE_LO] = ctrl[regSel].code;
          next_rdData[`CSE_CTRL_EXT_BIT]                   = ctrl[regSel].ext;
          next_rdData[`CSE_CTRL_EN_BIT]                    = ctrl[regSel].en;
        end
        `CSE_OFS_COUNT0, `CSE_OFS_COUNT1, `CSE_OFS_COUNT2, `CSE_OFS_COUNT3:
          next_rdData = countVal[regSel];
        `CSE_OFS_FILTER:
          next_rdData[`CSE_FILT_HI:`CSE_FILT_LO] = filter;
        `CSE_OFS_STATUS:
          for (int i = 0; i < 15; i++)
            next_rdData[i] = (dly[i] == cse_pkg::DLY_WAIT);
        default:
          next_rdData = `CSE_RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      filter <= `CSE_RST_FILTER;
      rdData <= `CSE_RD_ZERO;
      // control words clear to disabled, so no counter runs before setup
      for (int k = 0; k < 4; k++)
        ctrl[k] <= '{en: 1'b0, ext: 1'b0, code: `CSE_RST_CODE};
    end
    else
    begin
      filter <= next_filter;
      rdData <= next_rdData;
      for (int k = 0; k < 4; k++)
        ctrl[k] <= next_ctrl[k];
    end
  end

  assign regRdata = rdData;

  // ==========================================================
  // four general counters
  // each slice sees every event and picks one by its own control word, so
  // two counters may watch the same event with no arbitration between them
  // every event reachable from each of counters 0..3
  // counts advance on ref_clk, the fixed counting clock
  for (genvar k = 0; k < 4; k++)
  begin : gCnt
    assign cnt[k].ctrl     = ctrl[k];
    assign cnt[k].load     = loadSel[k];
    assign cnt[k].loadVal  = regWdata;
    assign cnt[k].transEvt = transEvt;
    assign cnt[k].rejEvt   = rejPulse;
    assign cnt[k].demEvt   = demEvt;
    assign countVal[k]     = cnt[k].count;

    cse_counter uCnt (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .bus     (cnt[k].slice)
    );
  end
endmodule : cse_sleep_events

/* File: test/cse_seq_model.sv */
// Purpose: far-side sleep sequencer stand-in driving the event inputs
// Assumes: tasks start and end on a rising edge
// Notes:   lines idle low between activities
`timescale 1ns/1ns
module cse_seq_model (
  input  wire logic   ref_clk,   // clock
  output logic [5:0]  seqBusy,   // cores 4..9 busy
  output logic [5:0]  fvChange,  // cores 4..9 f/v step
  output logic [14:0] deepReq,   // deep request
  output logic [14:0] wakeEvt,   // wake
  output logic [14:0] timerDone, // timer expired
  output logic        demote0    // core 0 demotion
);
  // ==========================================
  // idle levels from time zero
  initial
  begin
    seqBusy = 6'h0;
    fvChange = 6'h0;
    deepReq = 15'h0;
    wakeEvt = 15'h0;
    timerDone = 15'h0;
    demote0 = 1'b0;
  end
  // own core only: n plain cycles, then m with f/v step
  task transition(input int i, input int n, input int m);
    seqBusy[i] <= 1'b1;
    repeat (n) @(posedge ref_clk);
    fvChange[i] <= 1'b1;
    repeat (m) @(posedge ref_clk);
    seqBusy[i] <= 1'b0;
    fvChange[i] <= 1'b0;
    @(posedge ref_clk);
  endtask : transition
  // request, then wake or timer one cycle later
  task deep(input int c, input bit w);
    deepReq[c] <= 1'b1;
    @(posedge ref_clk);
    deepReq[c] <= 1'b0;
    if (w)
      wakeEvt[c] <= 1'b1;
    else
      timerDone[c] <= 1'b1;
    @(posedge ref_clk);
    wakeEvt[c] <= 1'b0;
    timerDone[c] <= 1'b0;
    @(posedge ref_clk);
  endtask : deep
  task demote();
    demote0 <= 1'b1;
    @(posedge ref_clk);
    demote0 <= 1'b0;
    @(posedge ref_clk);
  endtask : demote
endmodule : cse_seq_model

/* File: test/cse_events_chk.sv */
// Purpose: port-level checks of the sleep event block
// Assumes: bound to cse_sleep_events
// Notes:   shadows CTRL0 and FILTER bit 0 from the write port
`timescale 1ns/1ns
module cse_events_chk (
  input wire logic        ref_clk,  // clock
  input wire logic        nrst,     // reset, low
  input wire logic [7:0]  regAddr,  // address
  input wire logic [31:0] regWdata, // write data
  input wire logic        regWr,    // write
  input wire logic        regRd,    // read
  input wire logic [31:0] regRdata, // read data
  input wire logic [5:0]  seqBusy,  // busy
  input wire logic [5:0]  fvChange, // f/v step
  input wire logic [14:0] deepReq,  // request
  input wire logic [14:0] wakeEvt,  // wake
  input wire logic        demote0   // demotion
);
  logic [31:0] ctl0;  // CTRL0 copy
  logic        filt0; // FILTER bit 0 copy
  // ==========================================
  // shadows follow writes only, so a design slip cannot hide here
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctl0 <= 32'h0;
      filt0 <= 1'b0;
    end
    else if (regWr && regAddr == 8'h00)
      ctl0 <= regWdata;
    else if (regWr && regAddr == 8'h20)
      filt0 <= regWdata[0];
  end
  wire logic rd0 = regRd && regAddr == 8'h10;
  wire logic tr0 = ctl0[22] && !ctl0[21] && ctl0[7:0] == 8'h74;
  wire logic dm0 = ctl0[22] && !ctl0[21] && ctl0[7:0] == 8'h1e;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_count_step:
    assert property (rd0 ##1 rd0 |=> regRdata - $past(regRdata) <= 32'h1)
    else $error("count moved by more than one");
  a_trans_inc:
    assert property (tr0 && rd0 ##1 rd0 |=> regRdata - $past(regRdata)
      == {31'h0, $past(seqBusy[0] && !fvChange[0], 2)})
    else $error("transition count step wrong");
  a_dem_inc:
    assert property (dm0 && rd0 ##1 rd0 |=> regRdata - $past(regRdata)
      == {31'h0, $past(demote0 && filt0, 2)})
    else $error("demotion count step wrong");
  a_hold_off:
    assert property (!ctl0[22] && rd0 ##1 rd0 |=> $stable(regRdata))
    else $error("disabled counter moved");
  a_load_step:
    assert property (regWr && regAddr == 8'h14 ##1 !regWr ##1 regRd && regAddr == 8'h14
      |=> regRdata - $past(regWdata, 3) <= 32'h2)
    else $error("loaded count off");
  a_wait_flag:
    assert property (deepReq[3] ##1 regRd && regAddr == 8'h24 |=> regRdata[3])
    else $error("waiting flag missing");
  a_wake_clear:
    assert property (wakeEvt[3] && !deepReq[3] ##1 regRd && regAddr == 8'h24
      |=> !regRdata[3])
    else $error("waiting flag kept after wake");
  a_filter_keep:
    assert property (regWr && regAddr == 8'h20 ##1 !regWr ##1 regRd && regAddr == 8'h20
      |=> regRdata[7:0] == $past(regWdata[7:0], 3))
    else $error("filter field lost");
endmodule : cse_events_chk

/* File: test/cse_tb.sv */
// Purpose: self-checking bench of the sleep event block
// Assumes: register port with read data one cycle late
// Notes:   tasks start and end on a rising edge
`timescale 1ns/1ns
module tb;
  logic ref_clk, nrst, regWr, regRd;
  logic [7:0] regAddr;
  cse_pkg::cse_word_type regWdata, x, y;
  wire logic [31:0] regRdata;
  wire logic [5:0] seqBusy, fvChange;
  wire logic [14:0] deepReq, wakeEvt, timerDone;
  wire logic demote0;
  int mismatches, n_checks, cycles;
  cse_sleep_events dut_u (.ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .seqBusy(seqBusy), .fvChange(fvChange), .deepReq(deepReq), .wakeEvt(wakeEvt),
    .timerDone(timerDone), .demote0(demote0));
  cse_seq_model model_u (.ref_clk(ref_clk), .seqBusy(seqBusy), .fvChange(fvChange),
    .deepReq(deepReq), .wakeEvt(wakeEvt), .timerDone(timerDone), .demote0(demote0));
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task chk(input cse_pkg::cse_word_type got, input cse_pkg::cse_word_type exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input cse_pkg::cse_word_type d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr
  task rd(input logic [7:0] a, output cse_pkg::cse_word_type d);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(negedge ref_clk) d = regRdata;
    @(posedge ref_clk);
  endtask : rd
  // two reads with no gap, so one cycle of counting lies between them
  task rd2(input logic [7:0] a, output cse_pkg::cse_word_type p, q);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    @(negedge ref_clk) p = regRdata;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(negedge ref_clk) q = regRdata;
    @(posedge ref_clk);
  endtask : rd2
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  // ==========================================
  // main sequence
  initial
  begin
    regAddr = 8'h00;
    regWdata = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    nrst = 1'b0;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    for (int k = 0; k < 4; k++)
    begin
      rd(8'(16 + 4 * k), x);
      chk(x, 32'h0);
      wr(8'(16 + 4 * k), 32'(32'h1230 + k));
      rd(8'(16 + 4 * k), x);
      chk(x, 32'(32'h1230 + k));
    end
    rd(8'h24, x);
    chk(x, 32'h0);
    rd(8'h30, x);
    chk(x, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 6; i++)
    begin
      wr(8'(4 * (i % 4)), 32'h0040_0000 | 32'(8'h74 + i));
      wr(8'(16 + 4 * (i % 4)), 32'h0);
      model_u.transition(i, 5, 3);
      model_u.transition((i + 1) % 6, 4, 0);
      rd(8'(16 + 4 * (i % 4)), x);
      chk(x, 32'h5);
    end
    wr(8'h00, 32'h0040_0074);
    fork
      model_u.transition(0, 12, 12);
      begin
        repeat (3) @(posedge ref_clk);
        rd2(8'h10, x, y);
        chk(y - x, 32'h1);
        repeat (10) @(posedge ref_clk);
        rd2(8'h10, x, y);
        chk(y - x, 32'h0);
      end
    join
    wr(8'h00, 32'h0000_0074);
    fork
      model_u.transition(0, 6, 0);
      rd2(8'h10, x, y);
    join
    chk(y, x);
    $display("test transitions done");
    for (int c = 0; c < 15; c++)
    begin
      wr(8'(4 * (c % 4)), 32'h0060_0000 | 32'(8'h17 + c));
      wr(8'(16 + 4 * (c % 4)), 32'h0);
      model_u.deep(c, 1'b1);
      model_u.deep(c, 1'b0);
      model_u.deep((c + 1) % 15, 1'b1);
      rd(8'(16 + 4 * (c % 4)), x);
      chk(x, 32'h1);
    end
    fork
      model_u.deep(3, 1'b1);
      begin
        @(posedge ref_clk);
        rd2(8'h24, x, y);
      end
    join
    chk(x, 32'h8);
    chk(y, 32'h0);
    $display("test rejections done");
    wr(8'h20, 32'h1);
    rd(8'h20, x);
    chk(x, 32'h1);
    wr(8'h00, 32'h0040_001e);
    wr(8'h10, 32'h0);
    model_u.deep(7, 1'b1);
    fork
      model_u.demote();
      rd2(8'h10, x, y);
    join
    chk(x, 32'h0);
    chk(y, 32'h1);
    wr(8'h20, 32'h0);
    fork
      model_u.demote();
      rd2(8'h10, x, y);
    join
    chk(y, 32'h1);
    $display("test demotions done");
    finish_test;
  end
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      $display("mismatch at %0t: timeout", $time);
      finish_test;
    end
  end
endmodule : tb
bind cse_sleep_events cse_events_chk chk_u (.ref_clk(ref_clk), .nrst(nrst),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata(regRdata), .seqBusy(seqBusy), .fvChange(fvChange), .deepReq(deepReq),
  .wakeEvt(wakeEvt), .demote0(demote0));
